// ==== src/bcs_pkg.sv ====
// constants shared by the buck channel sequencer and its pwm core
// assumes a single 200 MHz reference clock drives every process
`default_nettype none

package bcs_pkg;

   // reference clock and derived time bases
   localparam int CLK_PERIOD_NS = 5;
   localparam int US_NS = 1000;
   localparam int US_CYC = US_NS / CLK_PERIOD_NS;
   localparam int MIN_ON_NS = 40;
   localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEQ_STEP_US = 250;
   localparam int OC_RESTART_MS = 200;
   localparam int OC_RESTART_US = OC_RESTART_MS * 1000;
   localparam int TMR_W = 18;

   // current limit register fields, sense in 5 mV steps
   localparam int ILIM_MAX_LSB = 0;
   localparam int ILIM_MAX_W = 6;
   localparam int ILIM_WARN_LSB = 6;
   localparam int ILIM_WARN_W = 2;
   localparam int ILIM_LSB_MV = 5;
   localparam int WARN_STEP_MV = 10;
   localparam int WARN_STEP_CODES = WARN_STEP_MV / ILIM_LSB_MV;
   localparam int SENSE_W = 7;

   // soft-start / soft-stop register fields
   localparam int SEQ_DLY_LSB = 10;
   localparam int SEQ_DLY_W = 6;
   localparam int SEQ_RAMP_LSB = 0;
   localparam int SEQ_RAMP_W = 10;

   // switching frequency select fields
   localparam int FREQ_OSC_LSB = 4;
   localparam int FREQ_OSC_W = 3;
   localparam int FREQ_DIV_LSB = 0;
   localparam int FREQ_DIV_W = 3;

   // oscillator modelled as a fractional tick: 3.2 MHz units, code 0 = 15 units
   localparam logic [4:0] OSC_BASE_UNITS = 5'h0_00F;
   localparam logic [6:0] OSC_ACC_MOD = 7'h0_07D;
   localparam int OSC_UNIT_KHZ = 3200;
   localparam int PWM_DIV_BASE = 16;
   localparam int MIN_SW_KHZ = 300;
   localparam int DUTY_FRAC_W = 8;

   typedef enum logic [2:0] {
      BCS_OFF     = 3'b000,
      BCS_SS_DLY  = 3'b001,
      BCS_SS_RAMP = 3'b011,
      BCS_ON      = 3'b010,
      BCS_SD_DLY  = 3'b110,
      BCS_SD_RAMP = 3'b111,
      BCS_FAULT   = 3'b101
   } bcs_state_t;

endpackage

`default_nettype wire

// ==== src/bcs_pwm_core.sv ====
// one channel's pwm pulse former: period and on-time in oscillator ticks
// assumes the oscillator tick is a one-cycle enable on the reference clock
`default_nettype none

module bcs_pwm_core (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // timing
   input wire logic i_osc_tick,
   input wire logic i_run,
   input wire logic [7:0] i_period,
   input wire logic [7:0] i_on_ticks,
   // gate drive
   output logic o_gate_high,
   output logic o_gate_low
);

   logic [7:0] phase_q;
   logic [3:0] hold_q;
   logic next_high;

   // a started pulse lasts at least the minimum on time while i_run stays high
   assign next_high = (o_gate_high && hold_q != 4'h0_000) || (phase_q < i_on_ticks);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !i_run)
      begin
         phase_q <= 8'h0_000;
         hold_q <= 4'h0_000;
         o_gate_high <= 1'b0;
         o_gate_low <= 1'b0;
      end
      else
      begin
         if (i_osc_tick)
         begin
            phase_q <= (phase_q >= i_period - 8'h0_001) ? 8'h0_000 : phase_q + 8'h0_001;
         end
         if (next_high && !o_gate_high)
         begin
            hold_q <= 4'(bcs_pkg::MIN_ON_CYC - 1);
         end
         else if (hold_q != 4'h0_000)
         begin
            hold_q <= hold_q - 4'h0_001;
         end
         o_gate_high <= next_high;
         o_gate_low <= !next_high;
      end
   end

endmodule // bcs_pwm_core

`default_nettype wire

// ==== src/bcs_channel_sequencer.sv ====
// multi-channel buck sequencer: over-current, soft-start/stop, power good, pwm
// assumes config, adc results and measurements come from logic on i_ref_clk
// Function
// - low six bits set max sense threshold
// - top two bits set warning offset below max
// - compare each adc result with warning threshold, and with max while driving
// - warning follows current, clears when below
// - fault stops drivers, waits 200 ms, restarts
// - follower channels restart the same way
// - fault sets sticky status flag
// - soft-start delay in 250 us steps
// - ramp target 50 mV per programmed microseconds
// - soft-stop delay in 250 us steps
// - ramp down until discharge level reached
// - power-good bounds held per channel
// - power good while output within window
// - power-good delay counts after soft-start
// - precharged output waits for soft-start end
// - oscillator code selects 48 down to 25.6 MHz
// - divider sets switching frequency, bad codes refused
// - high-side pulse not shorter than 40 ns while the channel keeps running
// - duty clamped at channel duty limit
`default_nettype none

module bcs_channel_sequencer #(
   parameter int NUM_CH = 3,
   parameter int STEP_US = bcs_pkg::SEQ_STEP_US,
   parameter int RESTART_US = bcs_pkg::OC_RESTART_US,
   parameter int CYC_PER_US = bcs_pkg::US_CYC
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // per-channel configuration
   input wire logic [NUM_CH-1:0] i_ch_enable,
   input wire logic [NUM_CH*8-1:0] i_current_limit,
   input wire logic [NUM_CH*16-1:0] i_soft_start,
   input wire logic [NUM_CH*16-1:0] i_soft_stop,
   input wire logic [NUM_CH*8-1:0] i_duty_limit,
   input wire logic [NUM_CH*8-1:0] i_vout_target,
   input wire logic [NUM_CH*8-1:0] i_discharge_level,
   input wire logic [NUM_CH*8-1:0] i_pg_upper,
   input wire logic [NUM_CH*8-1:0] i_pg_lower,
   input wire logic [NUM_CH*8-1:0] i_pg_delay,
   input wire logic [NUM_CH-1:0] i_oc_fault_clear,
   // shared configuration
   input wire logic [7:0] i_sw_freq_select,
   input wire logic [7:0] i_follow_low,
   input wire logic [7:0] i_follow_high,
   // measurements and loop request
   input wire logic [NUM_CH-1:0] i_adc_valid,
   input wire logic [NUM_CH*bcs_pkg::SENSE_W-1:0] i_adc_sense,
   input wire logic [NUM_CH*8-1:0] i_vout_meas,
   input wire logic [NUM_CH*8-1:0] i_duty_req,
   // gate drive and target
   output logic [NUM_CH-1:0] o_gate_high,
   output logic [NUM_CH-1:0] o_gate_low,
   output logic [NUM_CH*8-1:0] o_target,
   // status
   output logic [NUM_CH-1:0] o_oc_fault,
   output logic [NUM_CH-1:0] o_oc_warn,
   output logic [NUM_CH-1:0] o_power_good,
   output logic [NUM_CH-1:0] o_soft_start_done,
   output logic [NUM_CH-1:0] o_duty_clamped,
   output logic o_freq_invalid
);

   localparam int TW = bcs_pkg::TMR_W;
   localparam int SW = bcs_pkg::SENSE_W;

   if (NUM_CH < 1 || NUM_CH * NUM_CH > 16 || RESTART_US >= 2 ** TW
       || STEP_US * 255 >= 2 ** TW || CYC_PER_US < 2 || CYC_PER_US > 256)
   begin : g_param_check
      $error("bcs_channel_sequencer: unsupported parameter values");
   end

   logic [15:0] follow_map;
   logic [7:0] us_cnt_q;
   logic us_tick;
   logic [6:0] osc_acc_q;
   logic osc_tick_q;
   logic [4:0] osc_inc;
   logic [7:0] osc_sum, period_q;
   logic [2:0] osc_code, div_code;
   logic [15:0] osc_khz, min_khz;
   logic [NUM_CH-1:0] oc_trip;

   assign follow_map = {i_follow_high, i_follow_low};
   assign osc_code = i_sw_freq_select[bcs_pkg::FREQ_OSC_LSB +: bcs_pkg::FREQ_OSC_W];
   assign div_code = i_sw_freq_select[bcs_pkg::FREQ_DIV_LSB +: bcs_pkg::FREQ_DIV_W];
   assign us_tick = (us_cnt_q == 8'(CYC_PER_US - 1));
   assign osc_inc = 5'((bcs_pkg::OSC_BASE_UNITS - {2'b00, osc_code}) << 1);
   assign osc_sum = {1'b0, osc_acc_q} + {3'b000, osc_inc};
   assign osc_khz = 16'((bcs_pkg::OSC_BASE_UNITS - {2'b00, osc_code}) * bcs_pkg::OSC_UNIT_KHZ);
   assign min_khz = 16'(bcs_pkg::PWM_DIV_BASE * bcs_pkg::MIN_SW_KHZ * ({1'b0, div_code} + 4'h0_001));

   // microsecond enable
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || us_tick)
      begin
         us_cnt_q <= 8'h0_000;
      end
      else
      begin
         us_cnt_q <= us_cnt_q + 8'h0_001;
      end
   end

   // fractional oscillator tick; the sum is one bit wider so it never wraps
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         osc_acc_q <= 7'h0_000;
         osc_tick_q <= 1'b0;
      end
      else if (osc_sum >= {1'b0, bcs_pkg::OSC_ACC_MOD})
      begin
         osc_acc_q <= 7'(osc_sum - {1'b0, bcs_pkg::OSC_ACC_MOD});
         osc_tick_q <= 1'b1;
      end
      else
      begin
         osc_acc_q <= osc_sum[6:0];
         osc_tick_q <= 1'b0;
      end
   end

   // switching period and refused combinations
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         period_q <= 8'h0_000;
         o_freq_invalid <= 1'b1;
      end
      else
      begin
         period_q <= 8'(bcs_pkg::PWM_DIV_BASE * ({1'b0, div_code} + 4'h0_001));
         o_freq_invalid <= (div_code == 3'h0_000) || (osc_khz < min_khz);
      end
   end

   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      bcs_pkg::bcs_state_t st_q;
      logic [TW-1:0] tmr_q, pg_cnt_q, ss_dly, ss_ramp, sd_dly, sd_ramp;
      logic [7:0] tgt_q, lim, meas, duty_req, duty_lim, duty_eff;
      logic [15:0] ss, sd, on_prod;
      logic [SW-1:0] sense, max_th, warn_off, warn_th;
      logic driving, run_q, restart_req, en;

      assign en = i_ch_enable[c];
      assign lim = i_current_limit[c*8 +: 8];
      assign ss = i_soft_start[c*16 +: 16];
      assign sd = i_soft_stop[c*16 +: 16];
      assign sense = i_adc_sense[c*SW +: SW];
      assign meas = i_vout_meas[c*8 +: 8];
      assign max_th = SW'(lim[bcs_pkg::ILIM_MAX_LSB +: bcs_pkg::ILIM_MAX_W]);
      assign warn_off = SW'(({2'b00, lim[bcs_pkg::ILIM_WARN_LSB +: bcs_pkg::ILIM_WARN_W]}
                         + 4'h0_001) * bcs_pkg::WARN_STEP_CODES);
      assign warn_th = (max_th > warn_off) ? max_th - warn_off : '0;
      assign ss_dly = TW'(ss[bcs_pkg::SEQ_DLY_LSB +: bcs_pkg::SEQ_DLY_W] * STEP_US);
      assign ss_ramp = TW'(ss[bcs_pkg::SEQ_RAMP_LSB +: bcs_pkg::SEQ_RAMP_W]);
      assign sd_dly = TW'(sd[bcs_pkg::SEQ_DLY_LSB +: bcs_pkg::SEQ_DLY_W] * STEP_US);
      assign sd_ramp = TW'(sd[bcs_pkg::SEQ_RAMP_LSB +: bcs_pkg::SEQ_RAMP_W]);
      assign driving = (st_q == bcs_pkg::BCS_SS_RAMP) || (st_q == bcs_pkg::BCS_ON)
                    || (st_q == bcs_pkg::BCS_SD_DLY) || (st_q == bcs_pkg::BCS_SD_RAMP);
      assign oc_trip[c] = i_adc_valid[c] && driving && (sense >= max_th);
      assign duty_req = i_duty_req[c*8 +: 8];
      assign duty_lim = i_duty_limit[c*8 +: 8];
      assign duty_eff = (duty_req > duty_lim) ? duty_lim : duty_req;
      assign on_prod = duty_eff * period_q;

      // own trip or a followed channel's trip
      always_comb
      begin
         restart_req = oc_trip[c];
         for (int f = 0; f < NUM_CH; f++)
         begin
            if (oc_trip[f] && follow_map[f*NUM_CH + c])
            begin
               restart_req = 1'b1;
            end
         end
      end

      // channel sequence on microsecond ticks
      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
         begin
            st_q <= bcs_pkg::BCS_OFF;
            tmr_q <= '0;
            tgt_q <= 8'h0_000;
         end
         else if (restart_req)
         begin
            st_q <= bcs_pkg::BCS_FAULT;
            tmr_q <= TW'(RESTART_US);
            tgt_q <= 8'h0_000;
         end
         else
         begin
            case (st_q)
               bcs_pkg::BCS_OFF, bcs_pkg::BCS_FAULT:
               begin
                  tgt_q <= 8'h0_000;
                  if (st_q == bcs_pkg::BCS_FAULT && !(us_tick && tmr_q <= TW'(1)))
                  begin
                     if (us_tick)
                     begin
                        tmr_q <= tmr_q - TW'(1);
                     end
                  end
                  else if (!en)
                  begin
                     st_q <= bcs_pkg::BCS_OFF;
                  end
                  else if (ss_dly == '0)
                  begin
                     st_q <= bcs_pkg::BCS_SS_RAMP;
                     tmr_q <= ss_ramp;
                  end
                  else
                  begin
                     st_q <= bcs_pkg::BCS_SS_DLY;
                     tmr_q <= ss_dly;
                  end
               end
               bcs_pkg::BCS_SS_DLY:
               begin
                  if (!en)
                  begin
                     st_q <= bcs_pkg::BCS_OFF;
                  end
                  else if (us_tick)
                  begin
                     if (tmr_q <= TW'(1))
                     begin
                        st_q <= bcs_pkg::BCS_SS_RAMP;
                        tmr_q <= ss_ramp;
                     end
                     else
                     begin
                        tmr_q <= tmr_q - TW'(1);
                     end
                  end
               end
               bcs_pkg::BCS_SS_RAMP:
               begin
                  if (!en)
                  begin
                     st_q <= bcs_pkg::BCS_SD_DLY;
                     tmr_q <= sd_dly;
                  end
                  else if (tgt_q >= i_vout_target[c*8 +: 8])
                  begin
                     st_q <= bcs_pkg::BCS_ON;
                  end
                  else if (us_tick)
                  begin
                     if (tmr_q <= TW'(1))
                     begin
                        tgt_q <= tgt_q + 8'h0_001;
                        tmr_q <= ss_ramp;
                     end
                     else
                     begin
                        tmr_q <= tmr_q - TW'(1);
                     end
                  end
               end
               bcs_pkg::BCS_ON:
               begin
                  tgt_q <= i_vout_target[c*8 +: 8];
                  if (!en)
                  begin
                     st_q <= bcs_pkg::BCS_SD_DLY;
                     tmr_q <= sd_dly;
                  end
               end
               bcs_pkg::BCS_SD_DLY:
               begin
                  if (en)
                  begin
                     st_q <= bcs_pkg::BCS_SS_RAMP;
                     tmr_q <= ss_ramp;
                  end
                  else if (sd_dly == '0 || (us_tick && tmr_q <= TW'(1)))
                  begin
                     st_q <= bcs_pkg::BCS_SD_RAMP;
                     tmr_q <= sd_ramp;
                  end
                  else if (us_tick)
                  begin
                     tmr_q <= tmr_q - TW'(1);
                  end
               end
               bcs_pkg::BCS_SD_RAMP:
               begin
                  if (en)
                  begin
                     st_q <= bcs_pkg::BCS_SS_RAMP;
                     tmr_q <= ss_ramp;
                  end
                  else if (tgt_q <= i_discharge_level[c*8 +: 8])
                  begin
                     st_q <= bcs_pkg::BCS_OFF;
                     tgt_q <= 8'h0_000;
                  end
                  else if (us_tick)
                  begin
                     if (tmr_q <= TW'(1))
                     begin
                        tgt_q <= tgt_q - 8'h0_001;
                        tmr_q <= sd_ramp;
                     end
                     else
                     begin
                        tmr_q <= tmr_q - TW'(1);
                     end
                  end
               end
               default:
               begin
                  st_q <= bcs_pkg::BCS_OFF;
               end
            endcase
         end
      end

      // power good: delay counts only after the ramp
      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
         begin
            pg_cnt_q <= '0;
            o_power_good[c] <= 1'b0;
            o_soft_start_done[c] <= 1'b0;
         end
         else
         begin
            if (st_q != bcs_pkg::BCS_ON)
            begin
               pg_cnt_q <= TW'(i_pg_delay[c*8 +: 8] * STEP_US);
            end
            else if (us_tick && pg_cnt_q != '0)
            begin
               pg_cnt_q <= pg_cnt_q - TW'(1);
            end
            o_power_good[c] <= (st_q == bcs_pkg::BCS_ON) && (pg_cnt_q == '0)
                            && (meas >= i_pg_lower[c*8 +: 8])
                            && (meas <= i_pg_upper[c*8 +: 8]);
            o_soft_start_done[c] <= (st_q == bcs_pkg::BCS_ON);
         end
      end

      // over-current flags: warning follows each sample, fault is sticky
      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
         begin
            o_oc_warn[c] <= 1'b0;
            o_oc_fault[c] <= 1'b0;
         end
         else
         begin
            if (i_adc_valid[c])
            begin
               o_oc_warn[c] <= (sense >= warn_th);
            end
            if (oc_trip[c])
            begin
               o_oc_fault[c] <= 1'b1;
            end
            else if (i_oc_fault_clear[c])
            begin
               o_oc_fault[c] <= 1'b0;
            end
         end
      end

      // duty clamp and target output
      always_ff @(posedge i_ref_clk)
      begin
         if (i_sys_rst)
         begin
            run_q <= 1'b0;
            o_duty_clamped[c] <= 1'b0;
            o_target[c*8 +: 8] <= 8'h0_000;
         end
         else
         begin
            run_q <= driving && !restart_req && !o_freq_invalid;
            o_duty_clamped[c] <= driving && (duty_req > duty_lim);
            o_target[c*8 +: 8] <= tgt_q;
         end
      end

      bcs_pwm_core u_pwm (
         .i_ref_clk(i_ref_clk),
         .i_sys_rst(i_sys_rst),
         .i_osc_tick(osc_tick_q),
         .i_run(run_q && !restart_req),
         .i_period(period_q),
         .i_on_ticks(on_prod[bcs_pkg::DUTY_FRAC_W +: 8]),
         .o_gate_high(o_gate_high[c]),
         .o_gate_low(o_gate_low[c])
      );
   end

endmodule // bcs_channel_sequencer

`default_nettype wire

// ==== tb/bcs_channel_sequencer_asserts.sv ====
// checker for the buck channel sequencer: channel 0 rules plus one follower
// assumes a bind into bcs_channel_sequencer with NUM_CH of at least 3
`default_nettype none

module bcs_channel_sequencer_asserts #(
   parameter int NUM_CH = 3
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // inputs watched
   input wire logic [NUM_CH*8-1:0] i_current_limit,
   input wire logic [NUM_CH*8-1:0] i_duty_limit,
   input wire logic [NUM_CH*8-1:0] i_pg_upper,
   input wire logic [NUM_CH*8-1:0] i_pg_lower,
   input wire logic [7:0] i_follow_low,
   input wire logic [NUM_CH-1:0] i_adc_valid,
   input wire logic [NUM_CH*bcs_pkg::SENSE_W-1:0] i_adc_sense,
   input wire logic [NUM_CH*8-1:0] i_vout_meas,
   input wire logic [NUM_CH*8-1:0] i_duty_req,
   // outputs watched
   input wire logic [NUM_CH-1:0] o_gate_high,
   input wire logic [NUM_CH-1:0] o_gate_low,
   input wire logic [NUM_CH*8-1:0] o_target,
   input wire logic [NUM_CH-1:0] o_oc_fault,
   input wire logic [NUM_CH-1:0] o_oc_warn,
   input wire logic [NUM_CH-1:0] o_power_good,
   input wire logic [NUM_CH-1:0] o_soft_start_done,
   input wire logic [NUM_CH-1:0] o_duty_clamped,
   input wire logic o_freq_invalid
);
   logic [6:0] max0, off0;
   logic [7:0] tgt0;
   logic warn0, trip0, in_win0, over0;

   // warning level floors at zero when the offset exceeds the limit
   assign max0 = {1'b0, i_current_limit[5:0]};
   assign off0 = {4'h0, i_current_limit[7:6], 1'b0} + 7'h02;
   assign warn0 = (max0 < off0) || (i_adc_sense[6:0] >= max0 - off0);
   assign trip0 = i_adc_valid[0] && (i_adc_sense[6:0] >= max0);
   assign in_win0 = (i_vout_meas[7:0] >= i_pg_lower[7:0]) && (i_vout_meas[7:0] <= i_pg_upper[7:0]);
   assign over0 = i_duty_req[7:0] > i_duty_limit[7:0];
   assign tgt0 = o_target[7:0];

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);

   property p_fault_set;
      trip0 && o_soft_start_done[0] |=> o_oc_fault[0];
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not set");

   property p_warn;
      i_adc_valid[0] |=> o_oc_warn[0] == $past(warn0);
   endproperty
   a_warn: assert property (p_warn) else $error("warn wrong");

   property p_warn_keep;
      !i_adc_valid[0] |=> $stable(o_oc_warn[0]);
   endproperty
   a_warn_keep: assert property (p_warn_keep) else $error("warn moved");

   property p_gates_off;
      $rose(o_oc_fault[0]) |-> ##1 (!o_gate_high[0] && !o_gate_low[0]) [*8];
   endproperty
   a_gates_off: assert property (p_gates_off) else $error("gates on in fault");

   property p_follow;
      trip0 && o_soft_start_done[0] && o_soft_start_done[2] && i_follow_low[2]
         |-> ##[1:2] o_target[23:16] == 8'h00;
   endproperty
   a_follow: assert property (p_follow) else $error("follower ran");

   property p_tgt_step;
      $changed(tgt0) |-> tgt0 == $past(tgt0) + 8'h01 || tgt0 == $past(tgt0) - 8'h01
         || tgt0 == 8'h00;
   endproperty
   a_tgt_step: assert property (p_tgt_step) else $error("target jump");

   property p_pg_rise;
      $rose(o_power_good[0]) |-> $past(o_soft_start_done[0]) && $past(in_win0);
   endproperty
   a_pg_rise: assert property (p_pg_rise) else $error("early power good");

   property p_pg_drop;
      o_power_good[0] && !in_win0 |=> !o_power_good[0];
   endproperty
   a_pg_drop: assert property (p_pg_drop) else $error("power good kept");

   property p_freq_block;
      o_freq_invalid [*3] |-> !(|o_gate_high);
   endproperty
   a_freq_block: assert property (p_freq_block) else $error("pulse at bad freq");

   property p_min_on;
      disable iff (i_sys_rst || o_freq_invalid || o_oc_fault[0] || tgt0 == 8'h00)
      $rose(o_gate_high[0]) |-> o_gate_high[0] [*8];
   endproperty
   a_min_on: assert property (p_min_on) else $error("short pulse");

   property p_clamp;
      $rose(o_duty_clamped[0]) |-> $past(over0);
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp no cause");

   c_fault: cover property ($rose(o_oc_fault[0]));
   c_pg: cover property ($rose(o_power_good[0]));
   c_clamp: cover property ($rose(o_duty_clamped[0]));
endmodule // bcs_channel_sequencer_asserts

`default_nettype wire

// ==== tb/bcs_load_model.sv ====
// load model: turns each channel's ramp target into a measured output voltage
// assumes targets in 50 mV units and measurements in 20 mV units
`default_nettype none

module bcs_load_model #(
   parameter int NUM_CH = 3
) (
   // clock
   input wire logic i_ref_clk,
   // channel side
   input wire logic [NUM_CH*8-1:0] i_target,
   input wire logic [NUM_CH*8-1:0] i_hold,
   // measurement
   output var logic [NUM_CH*8-1:0] o_vout_meas = '0
);
   // a nonzero hold stands for a precharged or disturbed output
   always_ff @(posedge i_ref_clk)
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (i_hold[c*8+:8] != 8'h00)
            o_vout_meas[c*8+:8] <= i_hold[c*8+:8];
         else
            o_vout_meas[c*8+:8] <= 8'((i_target[c*8+:8] * 5) / 2);
      end
   end
endmodule // bcs_load_model

`default_nettype wire

// ==== tb/bcs_channel_sequencer_bench.sv ====
// self-checking bench for the buck channel sequencer with shortened timers
// assumes the checker and load model are compiled first; step is 8 cycles
`default_nettype none

module bcs_channel_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [2:0] i_ch_enable = 3'b000;
   logic [23:0] i_current_limit = {3{8'h54}};
   logic [47:0] i_soft_start = {16'h0001, 16'h0801, 16'h0001};
   logic [47:0] i_soft_stop = {3{16'h0401}};
   logic [23:0] i_duty_limit = {3{8'hDC}};
   logic [23:0] i_vout_target = {3{8'h04}};
   logic [23:0] i_discharge_level = {3{8'h01}};
   logic [23:0] i_pg_upper = {3{8'h0C}};
   logic [23:0] i_pg_lower = {3{8'h08}};
   logic [23:0] i_pg_delay = {3{8'h01}};
   logic [2:0] i_oc_fault_clear = 3'b000;
   logic [7:0] i_sw_freq_select = 8'h02;
   logic [7:0] i_follow_low = 8'h04;
   logic [7:0] i_follow_high = 8'h00;
   logic [2:0] i_adc_valid = 3'b000;
   logic [20:0] i_adc_sense = 21'h0;
   logic [23:0] i_duty_req = {3{8'h80}};
   logic [23:0] load_hold = {8'h00, 8'h0A, 8'h00};
   logic [23:0] i_vout_meas;
   logic [2:0] gh, flt, wrn, pg, ssd, clp;
   logic [23:0] tgt;
   logic finv;
   int bad_count = 0;
   int n_tests = 0;
   int i;

   bcs_channel_sequencer #(.NUM_CH(3), .STEP_US(2), .RESTART_US(50), .CYC_PER_US(4)) dut_u (
      .i_ref_clk, .i_sys_rst, .i_ch_enable, .i_current_limit, .i_soft_start, .i_soft_stop,
      .i_duty_limit, .i_vout_target, .i_discharge_level, .i_pg_upper, .i_pg_lower, .i_pg_delay,
      .i_oc_fault_clear, .i_sw_freq_select, .i_follow_low, .i_follow_high, .i_adc_valid,
      .i_adc_sense, .i_vout_meas, .i_duty_req, .o_gate_high(gh), .o_gate_low(), .o_target(tgt),
      .o_oc_fault(flt), .o_oc_warn(wrn), .o_power_good(pg), .o_soft_start_done(ssd),
      .o_duty_clamped(clp), .o_freq_invalid(finv));

   bcs_load_model #(.NUM_CH(3)) load_u (
      .i_ref_clk, .i_target(tgt), .i_hold(load_hold), .o_vout_meas(i_vout_meas));

   initial
   begin
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
      n_tests++;
      if (got !== ex)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   // one valid sample on channel 0
   task automatic adc(input logic [6:0] s);
      @(negedge i_ref_clk);
      i_adc_valid = 3'b001;
      i_adc_sense[6:0] = s;
      @(negedge i_ref_clk);
      i_adc_valid = 3'b000;
      cyc(1);
   endtask

   task automatic wait_on;
      for (int k = 0; k < 400 && ssd !== 3'b111; k++)
         cyc(1);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (6000) @(posedge i_ref_clk);
      bad_count++;
      print_verdict();
   end

   initial
   begin
      cyc(10);
      chk("reset outputs", 24'h0, {tgt[7:0], flt, pg, ssd, 1'b0, ~finv});
      i_sys_rst = 1'b0;
      cyc(3);
      chk("freq valid", 24'h0, 24'(finv));
      i_ch_enable = 3'b111;
      cyc(12);
      chk("delay target", 24'h0, 24'({tgt[15:8], gh[1]}));
      chk("precharge pg", 24'h0, 24'(pg[1]));
      chk("zero delay ramp", 24'h1, 24'(tgt[7:0] != 8'h00));
      wait_on();
      chk("pg at done", 24'h0, 24'(pg[1]));
      chk("final target", {3{8'h04}}, tgt);
      cyc(12);
      chk("pg set", 24'h7, 24'(pg));
      load_hold[7:0] = 8'h14;
      cyc(3);
      chk("pg out of window", 24'h0, 24'(pg[0]));
      load_hold[7:0] = 8'h00;
      $display("test start done");
      for (i = 0; i < 64; i++)
      begin
         i_sw_freq_select = {1'b0, i[5:3], 1'b0, i[2:0]};
         cyc(2);
         chk("freq invalid", 24'((i % 8 == 0) || (3200 * (15 - i / 8) < 4800 * (i % 8 + 1))),
            24'(finv));
      end
      i_sw_freq_select = 8'h02;
      i_duty_req[7:0] = 8'hF0;
      cyc(3);
      chk("clamp on", 24'h1, 24'(clp[0]));
      i_duty_req[7:0] = 8'h80;
      cyc(3);
      chk("clamp off", 24'h0, 24'(clp[0]));
      $display("test freq done");
      for (i = 0; i < 4; i++)
      begin
         i_current_limit[7:0] = {i[1:0], 6'h14};
         adc(7'(17 - 2 * i));
         chk("warn below", 24'h0, 24'(wrn[0]));
         adc(7'(18 - 2 * i));
         chk("warn at", 24'h1, 24'(wrn[0]));
      end
      adc(7'h13);
      chk("no fault below", 24'h0, 24'(flt));
      adc(7'h14);
      chk("fault flags", 24'h1, 24'(flt));
      chk("follower off", 24'h0, 24'({tgt[23:16], gh[0]}));
      cyc(150);
      chk("restart wait", 24'h0, 24'({ssd[0], ssd[2], gh[0]}));
      wait_on();
      chk("restarted", 24'h7, 24'(ssd));
      i_oc_fault_clear = 3'b001;
      cyc(2);
      i_oc_fault_clear = 3'b000;
      chk("fault cleared", 24'h0, 24'(flt));
      adc(7'h14);
      chk("fault again", 24'h1, 24'(flt));
      cyc(150);
      wait_on();
      chk("restarted again", 24'h7, 24'(ssd));
      $display("test overcurrent done");
      i_ch_enable = 3'b110;
      cyc(4);
      chk("stop delay", 24'h4, 24'(tgt[7:0]));
      for (i = 0; i < 100 && tgt[7:0] !== 8'h00; i++)
         cyc(1);
      cyc(2);
      chk("stopped", 24'h0, 24'({tgt[7:0], gh[0], ssd[0]}));
      $display("test stop done");
      print_verdict();
   end
endmodule // bcs_channel_sequencer_bench

bind bcs_channel_sequencer bcs_channel_sequencer_asserts #(.NUM_CH(NUM_CH)) chk_u (
   .i_ref_clk, .i_sys_rst, .i_current_limit, .i_duty_limit, .i_pg_upper, .i_pg_lower,
   .i_follow_low, .i_adc_valid, .i_adc_sense, .i_vout_meas, .i_duty_req, .o_gate_high,
   .o_gate_low, .o_target, .o_oc_fault, .o_oc_warn, .o_power_good, .o_soft_start_done,
   .o_duty_clamped, .o_freq_invalid);

`default_nettype wire
